// [pap_adc_model.sv]
// Sample source and power consumer around the power datapath
`timescale 1ns/1ps
module pap_adc_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        inst_vld,
  input  wire logic [23:0] v_lvl,
  input  wire logic [23:0] i_lvl,
  output logic      [23:0] volt_a,
  output logic      [23:0] volt_b,
  output logic      [23:0] volt_c,
  output logic      [23:0] curr_a,
  output logic      [23:0] curr_b,
  output logic      [23:0] curr_c,
  output logic      [31:0] smp_gap
);
  logic [31:0] cnt_r;

  // ==========================================================
  // Sample levels, signs differ per phase
  assign volt_a = v_lvl;
  assign volt_b = -v_lvl;
  assign volt_c = v_lvl;
  assign curr_a = i_lvl;
  assign curr_b = i_lvl;
  assign curr_c = -i_lvl;

  // ==========================================================
  // Cycles between instantaneous power valid pulses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r   <= 32'h0000_0001;
      smp_gap <= 32'h0000_0000;
    end else if (inst_vld) begin
      smp_gap <= cnt_r;
      cnt_r   <= 32'h0000_0001;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end
endmodule // pap_adc_model

// [pap_datapath.sv]
// Module: three-phase active power datapath with calibration registers
//
// How it works
// - Power equals voltage sample times current sample
// - Low-pass filter extracts average active power
// - Instantaneous power register scaled to constant/16
// - Instantaneous power registers: 24 bits, readable
// - Compensation bit 14 selects 50/60 Hz
// - Voltage scale word: top zero, sign extended
// - Fundamental result settles within 375/875 ms
// - Gain multiplies filter output by one plus value
// - 0xC00000 halves, 0x400000 adds half
// - Separate gains for total and fundamental paths
// - Gain words: top zero, sign extended
// - Signed offset per phase per path
// - Offset LSB equals multiplier output LSB
// - Offset words: top zero, sign extended
// - Powers computed once per 8 kHz sample
`timescale 1ns/1ps
module pap_datapath
  import pap_pkg::*;
#(
  parameter int SMP_CYC = SMP_PERIOD_CYC
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [23:0] volt_a,
  input  wire logic [23:0] volt_b,
  input  wire logic [23:0] volt_c,
  input  wire logic [23:0] curr_a,
  input  wire logic [23:0] curr_b,
  input  wire logic [23:0] curr_c,
  input  wire logic [4:0]  reg_sel,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             inst_vld,
  output logic      [23:0] phase_a_inst_power,
  output logic      [23:0] phase_b_inst_power,
  output logic      [23:0] phase_c_inst_power,
  output logic             avg_vld,
  output logic      [27:0] tot_avg_a,
  output logic      [27:0] tot_avg_b,
  output logic      [27:0] tot_avg_c,
  output logic      [27:0] fund_avg_a,
  output logic      [27:0] fund_avg_b,
  output logic      [27:0] fund_avg_c
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0]       timer;
    logic              prod_vld;
    logic              inst_vld;
    logic [2:0][27:0]  prod;
    logic [2:0][23:0]  inst;
    logic [23:0]       nominal_voltage_scale;
    logic [15:0]       comp;
    logic [5:0][23:0]  gain;
    logic [5:0][23:0]  offs;
    logic [31:0]       rdata;
  } pap_state_type;

  pap_state_type st_r;
  pap_state_type st_nxt;

  logic [2:0][23:0] volt;
  logic [2:0][23:0] curr;
  logic [5:0][27:0] avg;
  logic [5:0]       avg_v;
  logic [3:0]       fund_shift;

  assign volt = {volt_c, volt_b, volt_a};
  assign curr = {curr_c, curr_b, curr_a};

  // ==========================================================
  // Helpers
  function automatic logic [27:0] mul_scale(input logic [23:0] v,
                                            input logic [23:0] i);
    logic signed [47:0] p;
    p = signed'(v) * signed'(i);
    return p[PROD_SHIFT+27:PROD_SHIFT];
  endfunction

  function automatic logic [23:0] inst_scale(input logic [27:0] p,
                                             input logic [23:0] o);
    logic signed [28:0] s;
    s = signed'({p[27], p}) + signed'({o[23], sx28(o)});
    return s[INST_SHIFT+23:INST_SHIFT];
  endfunction

  function automatic logic [31:0] rd_mux(input pap_state_type s,
                                         input logic [4:0]    sel);
    logic [31:0] w;
    w = '0;
    if (sel < IDX_NOMINAL_VOLTAGE_SCALE) begin
      w = {8'h00, s.inst[sel[1:0]]};
    end else if (sel == IDX_NOMINAL_VOLTAGE_SCALE) begin
      w = cal_word(s.nominal_voltage_scale);
    end else if (sel == IDX_COMP) begin
      w = {16'h0000, s.comp};
    end else if (sel >= IDX_GAIN_0 && sel < IDX_OFFS_0) begin
      w = cal_word(s.gain[3'(sel - IDX_GAIN_0)]);
    end else if (sel >= IDX_OFFS_0 && sel < IDX_OFFS_0 + 5'd6) begin
      w = cal_word(s.offs[3'(sel - IDX_OFFS_0)]);
    end
    return w;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.prod_vld = 1'b0;
    st_nxt.inst_vld = 1'b0;
    // Sample timer
    if (st_r.timer == 32'(SMP_CYC - 1)) begin
      st_nxt.timer = '0;
      st_nxt.prod_vld = 1'b1;
      for (int p = 0; p < 3; p++) begin
        st_nxt.prod[p] = mul_scale(volt[p], curr[p]);
      end
    end else begin
      st_nxt.timer = st_r.timer + 32'd1;
    end
    // Waveform registers
    if (st_r.prod_vld) begin
      st_nxt.inst_vld = 1'b1;
      for (int p = 0; p < 3; p++) begin
        st_nxt.inst[p] = inst_scale(st_r.prod[p], st_r.offs[p]);
      end
    end
    // Register writes
    if (reg_wr) begin
      if (reg_sel == IDX_NOMINAL_VOLTAGE_SCALE) begin
        st_nxt.nominal_voltage_scale = reg_wdata[23:0];
      end else if (reg_sel == IDX_COMP) begin
        st_nxt.comp = reg_wdata[15:0];
      end else if (reg_sel >= IDX_GAIN_0 && reg_sel < IDX_OFFS_0) begin
        st_nxt.gain[3'(reg_sel - IDX_GAIN_0)] = reg_wdata[23:0];
      end else if (reg_sel >= IDX_OFFS_0 && reg_sel < IDX_OFFS_0 + 5'd6) begin
        st_nxt.offs[3'(reg_sel - IDX_OFFS_0)] = reg_wdata[23:0];
      end
    end
    // Register reads
    if (reg_rd) begin
      st_nxt.rdata = rd_mux(st_r, reg_sel);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Power paths: 0..2 total, 3..5 fundamental
  assign fund_shift = st_r.comp[FREQ_SEL_BIT] ? LPF_SHIFT_FUND_60
                                              : LPF_SHIFT_FUND_50;

  for (genvar g = 0; g < 6; g++) begin : g_path
    pap_power_path u_path (
      .core_clk  (core_clk),
      .rst       (rst),
      .ce        (ce),
      .in_vld    (st_r.prod_vld),
      .in_pwr    (st_r.prod[g % 3]),
      .offs      (st_r.offs[g]),
      .gain      (st_r.gain[g]),
      .lpf_shift ((g < 3) ? LPF_SHIFT_TOT : fund_shift),
      .avg_pwr   (avg[g]),
      .avg_vld   (avg_v[g])
    );
  end

  // ==========================================================
  // Outputs
  assign reg_rdata          = st_r.rdata;
  assign inst_vld           = st_r.inst_vld;
  assign phase_a_inst_power = st_r.inst[0];
  assign phase_b_inst_power = st_r.inst[1];
  assign phase_c_inst_power = st_r.inst[2];
  assign avg_vld            = avg_v[0];
  assign tot_avg_a          = avg[0];
  assign tot_avg_b          = avg[1];
  assign tot_avg_c          = avg[2];
  assign fund_avg_a         = avg[3];
  assign fund_avg_b         = avg[4];
  assign fund_avg_c         = avg[5];

  // ==========================================================
  // Checks
  property p_product;
    @(posedge core_clk) disable iff (rst)
      ce && st_r.timer == 32'(SMP_CYC - 1)
      |=> st_r.prod[0] == mul_scale($past(volt_a), $past(curr_a));
  endproperty
  a_product: assert property (p_product)
    else $error("phase product does not match samples");

  property p_inst;
    @(posedge core_clk) disable iff (rst)
      ce && st_r.prod_vld
      |=> inst_vld && phase_b_inst_power ==
          inst_scale($past(st_r.prod[1]), $past(st_r.offs[1]));
  endproperty
  a_inst: assert property (p_inst)
    else $error("instantaneous power not scaled by sixteen");

  property p_inst_read;
    @(posedge core_clk) disable iff (rst)
      ce && reg_rd && reg_sel == IDX_INST_A
      |=> reg_rdata == {8'h00, $past(st_r.inst[0])};
  endproperty
  a_inst_read: assert property (p_inst_read)
    else $error("instantaneous power read back wrong");

  property p_nominal_voltage_scale_word;
    @(posedge core_clk) disable iff (rst)
      ce && reg_wr && reg_sel == IDX_NOMINAL_VOLTAGE_SCALE ##1
      ce && !reg_wr ##1
      ce && reg_rd && !reg_wr && reg_sel == IDX_NOMINAL_VOLTAGE_SCALE
      |=> reg_rdata[31:28] == 4'h0 &&
          reg_rdata[27:0] == sx28($past(reg_wdata[23:0], 3));
  endproperty
  a_nominal_voltage_scale_word: assert property (p_nominal_voltage_scale_word)
    else $error("voltage scale word not sign extended");

  property p_gain_word;
    @(posedge core_clk) disable iff (rst)
      ce && reg_wr && reg_sel == IDX_GAIN_0 + 5'd3 ##1
      ce && !reg_wr ##1
      ce && reg_rd && !reg_wr && reg_sel == IDX_GAIN_0 + 5'd3
      |=> reg_rdata == cal_word($past(reg_wdata[23:0], 3));
  endproperty
  a_gain_word: assert property (p_gain_word)
    else $error("gain word not sign extended");

  property p_offs_word;
    @(posedge core_clk) disable iff (rst)
      ce && reg_wr && reg_sel == IDX_OFFS_0 + 5'd5 ##1
      ce && !reg_wr ##1
      ce && reg_rd && !reg_wr && reg_sel == IDX_OFFS_0 + 5'd5
      |=> reg_rdata == cal_word($past(reg_wdata[23:0], 3));
  endproperty
  a_offs_word: assert property (p_offs_word)
    else $error("offset word not sign extended");

  property p_rate;
    @(posedge core_clk) disable iff (rst)
      ce && st_r.prod_vld |=> !st_r.prod_vld [*8];
  endproperty
  a_rate: assert property (p_rate)
    else $error("power computed more than once per sample");

  property p_freq_default;
    @(posedge core_clk)
      $past(rst) |-> !st_r.comp[FREQ_SEL_BIT] && fund_shift == LPF_SHIFT_FUND_50;
  endproperty
  a_freq_default: assert property (p_freq_default)
    else $error("line frequency select not 50 Hz after reset");

  property p_freq_sel;
    @(posedge core_clk) disable iff (rst)
      ce && reg_wr && reg_sel == IDX_COMP && reg_wdata[FREQ_SEL_BIT]
      |=> fund_shift == LPF_SHIFT_FUND_60;
  endproperty
  a_freq_sel: assert property (p_freq_sel)
    else $error("60 Hz select did not reach fundamental filter");

  property p_avg_follow;
    @(posedge core_clk) disable iff (rst)
      ce && st_r.prod_vld ##1 ce |=> avg_vld;
  endproperty
  a_avg_follow: assert property (p_avg_follow)
    else $error("average power not produced two cycles after product");

  property p_inst_ro;
    @(posedge core_clk) disable iff (rst)
      ce && reg_wr && reg_sel == IDX_INST_A && !st_r.prod_vld |=> $stable(st_r.inst[0]);
  endproperty
  a_inst_ro: assert property (p_inst_ro)
    else $error("read-only power register was written");

  property p_rdata_hold;
    @(posedge core_clk) disable iff (rst)
      ce && !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_freq_50;
    @(posedge core_clk) disable iff (rst)
      ce && reg_wr && reg_sel == IDX_COMP && !reg_wdata[FREQ_SEL_BIT]
      |=> fund_shift == LPF_SHIFT_FUND_50;
  endproperty
  a_freq_50: assert property (p_freq_50)
    else $error("50 Hz select did not reach fundamental filter");

  property p_avg_all;
    @(posedge core_clk) disable iff (rst)
      avg_vld |-> avg_v == 6'h3F;
  endproperty
  a_avg_all: assert property (p_avg_all)
    else $error("power paths out of step");

  property p_timer_range;
    @(posedge core_clk) disable iff (rst)
      st_r.timer <= 32'(SMP_CYC - 1);
  endproperty
  a_timer_range: assert property (p_timer_range)
    else $error("sample timer beyond one sample period");

endmodule // pap_datapath

// [pap_pkg.sv]
// Package: constants and helpers for the phase active power datapath
package pap_pkg;

  // ==========================================================
  // Widths
  localparam int SMP_W = 24;
  localparam int INT_W = 28;
  localparam int REG_W = 32;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SMP_PERIOD_NS  = 125000;
  localparam int SMP_PERIOD_CYC = SMP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SETTLE_63_MS   = 375;
  localparam int SETTLE_FULL_MS = 875;
  localparam int SETTLE_63_SMP  = SETTLE_63_MS * 1000000 / SMP_PERIOD_NS;
  localparam int SETTLE_FULL_SMP = SETTLE_FULL_MS * 1000000 / SMP_PERIOD_NS;

  // ==========================================================
  // Scaling
  localparam int FULL_SCALE_POWER = 33516139;
  localparam int NOMINAL_VOLTAGE_SCALE_MULT      = 491520;
  localparam int PROD_SHIFT       = 20;
  localparam int INST_SHIFT       = 4;
  localparam int GAIN_FRAC        = 23;
  localparam logic [3:0] LPF_SHIFT_TOT     = 4'h8;
  localparam logic [3:0] LPF_SHIFT_FUND_50 = 4'hA;
  localparam logic [3:0] LPF_SHIFT_FUND_60 = 4'h9;

  // ==========================================================
  // Register map (word indices) and reset values
  localparam int FREQ_SEL_BIT = 14;
  localparam logic [4:0] IDX_INST_A = 5'h00;
  localparam logic [4:0] IDX_NOMINAL_VOLTAGE_SCALE = 5'h03;
  localparam logic [4:0] IDX_COMP   = 5'h04;
  localparam logic [4:0] IDX_GAIN_0 = 5'h05;
  localparam logic [4:0] IDX_OFFS_0 = 5'h0B;
  localparam logic [15:0] COMP_RST  = 16'h0000;
  localparam logic [23:0] CAL_RST   = 24'h00_0000;

  // Sign extend a 24-bit calibration value to the internal width
  function automatic logic [27:0] sx28(input logic [23:0] v);
    return {{4{v[23]}}, v};
  endfunction

  // Word view of a 24-bit signed calibration register
  function automatic logic [31:0] cal_word(input logic [23:0] v);
    return {4'h0, sx28(v)};
  endfunction

endpackage

// [pap_power_path.sv]
// Module: one offset, low-pass filter and gain power path
`timescale 1ns/1ps
module pap_power_path
  import pap_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        in_vld,
  input  wire logic [27:0] in_pwr,
  input  wire logic [23:0] offs,
  input  wire logic [23:0] gain,
  input  wire logic [3:0]  lpf_shift,
  output logic      [27:0] avg_pwr,
  output logic             avg_vld
);

  typedef struct packed {
    logic [27:0] acc;
    logic        stg;
    logic [27:0] out;
    logic        vld;
  } pap_path_state_type;

  pap_path_state_type st_r;
  pap_path_state_type st_nxt;

  // ==========================================================
  // Datapath
  always_comb begin
    logic signed [29:0] x;
    logic signed [29:0] d;
    logic signed [29:0] step;
    logic signed [55:0] m;
    x = '0;
    d = '0;
    step = '0;
    m = '0;
    st_nxt = st_r;
    st_nxt.stg = 1'b0;
    st_nxt.vld = 1'b0;
    x = signed'({{2{in_pwr[27]}}, in_pwr}) + signed'({{2{offs[23]}}, sx28(offs)});
    d = x - signed'({{2{st_r.acc[27]}}, st_r.acc});
    step = d >>> lpf_shift;
    if (in_vld) begin
      st_nxt.acc = st_r.acc + step[27:0];
      st_nxt.stg = 1'b1;
    end
    m = signed'(st_r.acc) * signed'(sx28(gain));
    if (st_r.stg) begin
      st_nxt.out = st_r.acc + m[GAIN_FRAC+27:GAIN_FRAC];
      st_nxt.vld = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign avg_pwr = st_r.out;
  assign avg_vld = st_r.vld;

  // ==========================================================
  // Checks
  logic [27:0] acc_neg;
  assign acc_neg = 28'h000_0000 - st_r.acc;

  property p_gain_unity;
    @(posedge core_clk) disable iff (rst)
      ce && st_r.stg && gain == CAL_RST |=> avg_pwr == $past(st_r.acc);
  endproperty
  a_gain_unity: assert property (p_gain_unity)
    else $error("zero gain did not pass filter output");

  property p_gain_up;
    @(posedge core_clk) disable iff (rst)
      ce && st_r.stg && gain == 24'h40_0000
      |=> avg_pwr == $past(st_r.acc + 28'(signed'(st_r.acc) >>> 1));
  endproperty
  a_gain_up: assert property (p_gain_up)
    else $error("gain 0x400000 did not add half");

  property p_gain_down;
    @(posedge core_clk) disable iff (rst)
      ce && st_r.stg && gain == 24'hC0_0000
      |=> avg_pwr == $past(st_r.acc + 28'(signed'(acc_neg) >>> 1));
  endproperty
  a_gain_down: assert property (p_gain_down)
    else $error("gain 0xC00000 did not remove half");

  property p_lpf_hold;
    @(posedge core_clk) disable iff (rst)
      ce && in_vld && (in_pwr + sx28(offs)) == st_r.acc |=> $stable(st_r.acc);
  endproperty
  a_lpf_hold: assert property (p_lpf_hold)
    else $error("filter moved at its dc value");

endmodule // pap_power_path

// [tb_phase_active_power_datapath.sv]
// Testbench for the phase active power datapath
`timescale 1ns/1ps
module tb_phase_active_power_datapath
  import pap_pkg::*;
;
  localparam int SMP = 400;
  logic        core_clk, rst, ce, reg_wr, reg_rd, inst_vld, avg_vld;
  logic [23:0] volt_a, volt_b, volt_c, curr_a, curr_b, curr_c, v_lvl, i_lvl;
  logic [4:0]  reg_sel;
  logic [31:0] reg_wdata, reg_rdata, smp_gap, rd_val;
  logic [23:0] inst_p [3];
  logic [27:0] tot_avg [3];
  logic [27:0] fund_avg [3];
  logic [23:0] gn [6];
  logic [23:0] of [6];
  longint      acc [6];
  longint      ie [3];
  int          err_total, cmp_count, vld_cnt, fsh;

  pap_datapath #(.SMP_CYC(SMP)) dut (
    .core_clk(core_clk), .rst(rst), .ce(ce),
    .volt_a(volt_a), .volt_b(volt_b), .volt_c(volt_c),
    .curr_a(curr_a), .curr_b(curr_b), .curr_c(curr_c),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .inst_vld(inst_vld),
    .phase_a_inst_power(inst_p[0]), .phase_b_inst_power(inst_p[1]),
    .phase_c_inst_power(inst_p[2]), .avg_vld(avg_vld),
    .tot_avg_a(tot_avg[0]), .tot_avg_b(tot_avg[1]), .tot_avg_c(tot_avg[2]),
    .fund_avg_a(fund_avg[0]), .fund_avg_b(fund_avg[1]), .fund_avg_c(fund_avg[2])
  );

  pap_adc_model adc (
    .core_clk(core_clk), .rst(rst), .inst_vld(inst_vld), .v_lvl(v_lvl),
    .i_lvl(i_lvl), .volt_a(volt_a), .volt_b(volt_b), .volt_c(volt_c),
    .curr_a(curr_a), .curr_b(curr_b), .curr_c(curr_c), .smp_gap(smp_gap)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (inst_vld === 1'b1) vld_cnt++;
  end

  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    reg_sel   <= idx;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] idx, output logic [31:0] d);
    @(posedge core_clk);
    reg_sel <= idx;
    reg_rd  <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  function automatic logic [31:0] cw(input logic [23:0] v);
    return {4'h0, {4{v[23]}}, v};
  endfunction

  function automatic logic [31:0] gained(input longint a, input logic [23:0] g);
    longint r;
    r = a + ((a * longint'($signed(g))) >>> 23);
    return {4'h0, r[27:0]};
  endfunction

  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // One sample through both paths of all phases
  task automatic smp_check(input int s);
    int          n;
    longint      xe;
    logic [23:0] va [3];
    logic [23:0] ca [3];
    n = 0;
    while (inst_vld !== 1'b1 && n < 2 * SMP) begin
      @(negedge core_clk);
      n++;
    end
    chk("inst_vld", 32'h0000_0001, {31'h0, inst_vld});
    va = '{volt_a, volt_b, volt_c};
    ca = '{curr_a, curr_b, curr_c};
    for (int p = 0; p < 3; p++) begin
      xe = (longint'($signed(va[p])) * longint'($signed(ca[p]))) >>> 20;
      ie[p] = (xe + longint'($signed(of[p]))) >>> 4;
      chk("inst_power", {8'h00, ie[p][23:0]}, {8'h00, inst_p[p]});
      acc[p] += (xe + longint'($signed(of[p])) - acc[p]) >>> 8;
      acc[p + 3] += (xe + longint'($signed(of[p + 3])) - acc[p + 3]) >>> fsh;
    end
    @(negedge core_clk);
    chk("avg_vld", 32'h0000_0001, {31'h0, avg_vld});
    if (s > 0) chk("smp_gap", 32'(SMP), smp_gap);
    for (int p = 0; p < 3; p++) begin
      chk("tot_avg", gained(acc[p], gn[p]), {4'h0, tot_avg[p]});
      chk("fund_avg", gained(acc[p + 3], gn[p + 3]), {4'h0, fund_avg[p]});
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = 5'h00;
    reg_wdata = 32'h0000_0000;
    v_lvl = 24'h00_0000;
    i_lvl = 24'h00_0000;
    err_total = 0;
    cmp_count = 0;
    vld_cnt = 0;
    fsh = 10;
    acc = '{6{64'sd0}};
    gn = '{24'h40_0000, 24'hC0_0000, 24'h00_0000, 24'h00_0100, 24'h80_0000, 24'h40_0000};
    of = '{24'h00_0010, 24'hFF_FFF0, 24'h00_0123, 24'hFF_F000, 24'h00_0800, 24'h00_0000};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 32; k++) begin
      rd(5'(k), rd_val);
      chk("reset_word", 32'h0000_0000, rd_val);
    end
    @(posedge core_clk);
    v_lvl <= 24'h40_0000;
    i_lvl <= 24'h20_0000;
    wr(IDX_NOMINAL_VOLTAGE_SCALE, 32'hF007_8000);
    wr(IDX_COMP, 32'hFFFF_0000);
    for (int k = 0; k < 6; k++) begin
      wr(IDX_GAIN_0 + 5'(k), {8'hA5, gn[k]});
      wr(IDX_OFFS_0 + 5'(k), {8'h5A, of[k]});
    end
    wr(IDX_INST_A, 32'h00FF_FFFF);
    wr(5'h1F, 32'hFFFF_FFFF);
    rd(IDX_NOMINAL_VOLTAGE_SCALE, rd_val);
    chk("nominal_voltage_scale", 32'h0007_8000, rd_val);
    rd(IDX_COMP, rd_val);
    chk("comp", 32'h0000_0000, rd_val);
    for (int k = 0; k < 6; k++) begin
      rd(IDX_GAIN_0 + 5'(k), rd_val);
      chk("gain", cw(gn[k]), rd_val);
      rd(IDX_OFFS_0 + 5'(k), rd_val);
      chk("offset", cw(of[k]), rd_val);
    end
    rd(IDX_INST_A, rd_val);
    chk("inst_ro", 32'h0000_0000, rd_val);
    rd(5'h1F, rd_val);
    chk("unmapped", 32'h0000_0000, rd_val);
    for (int s = 0; s < 16; s++) begin
      if (s == 8) begin
        wr(IDX_COMP, 32'h0000_4000);
        fsh = 9;
        rd(IDX_COMP, rd_val);
        chk("comp", 32'h0000_4000, rd_val);
      end
      smp_check(s);
    end
    for (int p = 0; p < 3; p++) begin
      rd(IDX_INST_A + 5'(p), rd_val);
      chk("inst_word", {8'h00, ie[p][23:0]}, rd_val);
    end
    wr(IDX_NOMINAL_VOLTAGE_SCALE, 32'h0007_8000);
    rd(IDX_NOMINAL_VOLTAGE_SCALE, rd_val);
    chk("nominal_voltage_scale_b2b", 32'h0007_8000, rd_val);
    wr(IDX_GAIN_0 + 5'd3, 32'hA580_0001);
    rd(IDX_GAIN_0 + 5'd3, rd_val);
    chk("gain_b2b", 32'h0F80_0001, rd_val);
    wr(IDX_OFFS_0 + 5'd5, 32'h5AFF_FFFF);
    rd(IDX_OFFS_0 + 5'd5, rd_val);
    chk("offset_b2b", 32'h0FFF_FFFF, rd_val);
    vld_cnt = 0;
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (3 * SMP) @(posedge core_clk);
    chk("frozen_pulses", 32'h0000_0000, 32'(vld_cnt));
    // Mid-run reset with zero current: every path sits at its dc value
    ce    <= 1'b1;
    rst   <= 1'b1;
    i_lvl <= 24'h00_0000;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    fsh = 10;
    acc = '{6{64'sd0}};
    gn = '{6{24'h00_0000}};
    of = '{6{24'h00_0000}};
    smp_check(0);
    end_of_test();
  end

  initial begin
    repeat (30 * SMP) @(posedge core_clk);
    err_total++;
    end_of_test();
  end
endmodule // tb_phase_active_power_datapath
